/* File: ckg_pkg.sv */
// Constants shared by the clock generator control logic.
// Assumes a system clock for the serial slave and an internal processor clock for gating.
// ==========================================================================

package ckg_pkg;

  // Serial slave identity and framing
  localparam logic [6:0] SLAVE_ADDR7 = 7'h69;
  localparam logic [7:0] RD_COUNT = 8'h06;
  localparam logic [3:0] CMD_SKIP = 4'h2;
  localparam logic [3:0] IDX_LAST = 4'h7;
  localparam logic [3:0] IDX_SAT = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int CFG_BYTES = 6;

  // Power-up defaults of bytes 5..0, strap bits overlaid on read-back
  localparam logic [47:0] CFG_RST = 48'hfff5_ff7f_7f00;

  // Strap latch positions
  localparam int STRAP_FS0 = 0;
  localparam int STRAP_FS1 = 1;
  localparam int STRAP_FS2 = 2;
  localparam int STRAP_FS3 = 3;
  localparam int STRAP_MODE = 4;
  localparam logic [4:0] STRAP_NONE = 5'h00;
  localparam logic [4:0] STRAP_ALL = 5'h1f;

  // Byte 0 fields
  localparam int B0_SPREAD_ON = 1;
  localparam int B0_FREQ_SRC = 3;
  localparam int B0_SPREAD_DOWN = 7;

  // Read-back strap overlay positions
  localparam int RB_FS_HI = 7;
  localparam int RB_FS1 = 3;
  localparam int RB_FS3 = 1;

  // Enable positions in the packed {byte5, byte3, byte2, byte1} vector
  localparam int EN_PROC0 = 0;
  localparam int EN_MEM_FREE = 3;
  localparam int EN_PROC_FREE = 6;
  localparam int EN_BUS0 = 8;
  localparam int EN_BUS_FREE = 14;
  localparam int EN_MEM_HI = 16;
  localparam int EN_REFERENCE_OUT_ZERO = 24;
  localparam int EN_REF1 = 25;
  localparam int EN_24M = 26;
  localparam int EN_48M = 27;
  localparam int EN_MEM_LO = 28;

  // Output toggle dividers in processor clock cycles
  localparam logic [1:0] BUS_DIV_LAST = 2'h1;
  localparam logic [1:0] AUX_DIV_LAST = 2'h3;

  // Serial slave states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ADDR = 6'b00_0010,
    ST_ACK_W = 6'b00_0100,
    ST_RX = 6'b00_1000,
    ST_TX = 6'b01_0000,
    ST_ACK_R = 6'b10_0000
  } ckg_ser_st_t;

endpackage : ckg_pkg

/* File: ckg_sync.sv */
// Two flip-flop level synchronizer, any width.
// Assumes the input is a level from another clock domain or a pin.
`timescale 1ns/1ps

module ckg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk, // Destination clock
  input wire logic [WIDTH-1:0] i_d, // Asynchronous levels
  output logic [WIDTH-1:0] o_q // Synchronized levels
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================================
  // Metastability filter: first stage feeds only the second
  always_ff @(posedge i_clk) begin
    meta_q <= i_d;
    o_q <= meta_q;
  end

endmodule : ckg_sync

/* File: ckg_gate.sv */
// Glitch-free gated clock outputs, one flip-flop per output.
// Assumes i_tick marks each half period and i_run is synchronous to i_clk.
`timescale 1ns/1ps

module ckg_gate #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk, // Internal processor clock
  input wire logic i_rstn, // Synchronous reset, active low
  input wire logic i_tick, // Half-period strobe
  input wire logic [WIDTH-1:0] i_run, // Enable and not halted
  output logic [WIDTH-1:0] o_q // Clock outputs
);

  // ==========================================================================
  // High phase always completes; a low output only rises while running
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_q <= '0;
    end else if (i_tick) begin
      o_q <= ~o_q & i_run;
    end
  end

endmodule : ckg_gate

/* File: ckg_ctrl.sv */
// Clock generator control: serial configuration slave, strap latch, clock stop logic.
// Assumes i_clk runs the serial slave and i_proc_clk is the internal processor clock.
`timescale 1ns/1ps

module ckg_ctrl (
  input wire logic i_clk, // System clock, 100 MHz
  input wire logic i_rstn, // Power-on reset, active low
  input wire logic i_proc_clk, // Internal processor clock
  input wire logic i_scl, // Serial clock pin
  input wire logic i_sda, // Serial data pin level
  output logic o_sda, // Serial data drive value
  output logic o_sda_oe, // Serial data drive enable
  input wire logic [4:0] i_strap_pin, // Dual-function pin levels
  output logic [4:0] o_strap_pin, // Dual-function pin clock values
  output logic [4:0] o_strap_oe, // Dual-function pin drive enables
  input wire logic i_reference_out_zero_pin, // Shared pin level, bus halt when mobile
  output logic o_reference_out_zero, // Shared pin clock value
  output logic o_reference_out_zero_oe, // Shared pin drive enable
  output logic o_ref1, // Second reference clock
  input wire logic i_proc_halt_n, // Processor clock halt, active low
  input wire logic i_mem_buf_in, // Memory fanout buffer input
  output logic [2:0] o_processor_clock_out, // Gated processor clocks
  output logic [4:1] o_bus_clock_out, // Gated bus clocks, bus 0 is on a strap pin
  output logic [11:0] o_mem_clock_out, // Gated memory fanout clocks
  output logic o_mem_free, // Free-running memory clock
  output logic [3:0] o_freq_sel, // Effective frequency select
  output logic o_spread_on, // Spread spectrum enable
  output logic o_spread_down // Spread spectrum down mode
);

  localparam int ACK_WAIT = 1000;
  localparam int CFG_BYTES = ckg_pkg::CFG_BYTES;

  // ==========================================================================
  // Serial pin sampling and bus events
  logic [1:0] ser_s;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  ckg_sync #(.WIDTH(2)) u_ser_sync (
    .i_clk(i_clk),
    .i_d({i_scl, i_sda}),
    .o_q(ser_s)
  );

  // Previous synchronized levels for edge detection
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= ser_s[1];
      sda_q <= ser_s[0];
    end
  end

  assign scl_rise = ser_s[1] & ~scl_q;
  assign scl_fall = ~ser_s[1] & scl_q;
  assign start_ev = ser_s[1] & scl_q & sda_q & ~ser_s[0];
  assign stop_ev = ser_s[1] & scl_q & ~sda_q & ser_s[0];

  // ==========================================================================
  // Strap latch and configuration bytes
  logic [4:0] strap_s;
  logic [4:0] strap_q;
  logic strap_done_q;
  logic [7:0] cfg_q [0:CFG_BYTES-1];
  logic wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_data;

  ckg_sync #(.WIDTH(5)) u_strap_sync (
    .i_clk(i_clk),
    .i_d(i_strap_pin),
    .o_q(strap_s)
  );

  // Capture straps once, right after power-on reset releases
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      strap_q <= ckg_pkg::STRAP_NONE;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q <= strap_s;
      strap_done_q <= 1'b1;
    end
  end

  // Strap pin drivers turn on once the straps are held, the shared pin driver only in desktop mode
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_strap_oe <= ckg_pkg::STRAP_NONE;
      o_reference_out_zero_oe <= 1'b0;
    end else begin
      o_strap_oe <= strap_done_q ? ckg_pkg::STRAP_ALL : ckg_pkg::STRAP_NONE;
      o_reference_out_zero_oe <= strap_done_q & strap_q[ckg_pkg::STRAP_MODE];
    end
  end

  // Configuration bytes with power-on defaults
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_q[i] <= ckg_pkg::CFG_RST[i*8 +: 8];
      end
    end else if (wr_en) begin
      cfg_q[wr_idx] <= wr_data;
    end
  end

  // Read-back value by transfer index: count first, then bytes with strap copies
  function automatic logic [7:0] rd_byte(input logic [3:0] idx);
    logic [7:0] v;
    logic [3:0] k;
    v = 8'h00;
    k = idx - 4'h1;
    if (idx == 4'h0) begin
      v = ckg_pkg::RD_COUNT;
    end else if (idx <= 4'h6) begin
      v = cfg_q[k[2:0]];
      case (k)
        4'h1: v[ckg_pkg::RB_FS_HI] = ~strap_q[ckg_pkg::STRAP_FS2];
        4'h2: v[ckg_pkg::RB_FS_HI] = ~strap_q[ckg_pkg::STRAP_FS0];
        4'h4: begin
          v[ckg_pkg::RB_FS1] = ~strap_q[ckg_pkg::STRAP_FS1];
          v[ckg_pkg::RB_FS3] = ~strap_q[ckg_pkg::STRAP_FS3];
        end
        default: v = v;
      endcase
    end
    return v;
  endfunction : rd_byte

  // ==========================================================================
  // Serial slave state machine
  ckg_pkg::ckg_ser_st_t state_q;
  logic [7:0] shreg_q;
  logic [2:0] bit_cnt_q;
  logic [3:0] byte_idx_q;
  logic [3:0] idx_next;
  logic rw_q;
  logic ack_on_q;
  logic [7:0] tx_byte;

  // Transmit byte follows the index and the stored bytes alike
  always_comb begin
    tx_byte = rd_byte(byte_idx_q);
  end
  assign idx_next = (byte_idx_q == ckg_pkg::IDX_SAT) ? byte_idx_q : byte_idx_q + 4'h1;
  assign wr_data = {shreg_q[6:0], ser_s[0]};
  assign wr_idx = byte_idx_q[2:0] - ckg_pkg::CMD_SKIP[2:0];
  // Command and count bytes fall outside the store window
  assign wr_en = (state_q == ckg_pkg::ST_RX) && scl_rise && (bit_cnt_q == ckg_pkg::BIT_LAST)
    && (byte_idx_q >= ckg_pkg::CMD_SKIP) && (byte_idx_q <= ckg_pkg::IDX_LAST);

  // Byte framing, acknowledge and transmit
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_q <= ckg_pkg::ST_IDLE;
      shreg_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      byte_idx_q <= 4'h0;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (start_ev) begin
      state_q <= ckg_pkg::ST_ADDR;
      bit_cnt_q <= 3'h0;
      byte_idx_q <= 4'h0;
      ack_on_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (stop_ev) begin
      state_q <= ckg_pkg::ST_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_q)
        ckg_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shreg_q <= wr_data;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == ckg_pkg::BIT_LAST) begin
              if (shreg_q[6:0] == ckg_pkg::SLAVE_ADDR7) begin
                rw_q <= ser_s[0];
                state_q <= ckg_pkg::ST_ACK_W;
              end else begin
                state_q <= ckg_pkg::ST_IDLE;
              end
            end
          end
        end
        ckg_pkg::ST_ACK_W: begin
          if (scl_fall) begin
            if (!ack_on_q) begin
              ack_on_q <= 1'b1;
              o_sda_oe <= 1'b1;
            end else begin
              ack_on_q <= 1'b0;
              bit_cnt_q <= 3'h0;
              if (rw_q) begin
                shreg_q <= tx_byte;
                o_sda_oe <= ~tx_byte[7];
                byte_idx_q <= idx_next;
                state_q <= ckg_pkg::ST_TX;
              end else begin
                o_sda_oe <= 1'b0;
                state_q <= ckg_pkg::ST_RX;
              end
            end
          end
        end
        ckg_pkg::ST_RX: begin
          if (scl_rise) begin
            shreg_q <= wr_data;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == ckg_pkg::BIT_LAST) begin
              byte_idx_q <= idx_next;
              state_q <= ckg_pkg::ST_ACK_W;
            end
          end
        end
        ckg_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_q == ckg_pkg::BIT_LAST) begin
              o_sda_oe <= 1'b0;
              state_q <= ckg_pkg::ST_ACK_R;
            end else begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
              shreg_q <= {shreg_q[6:0], 1'b0};
              o_sda_oe <= ~shreg_q[6];
            end
          end
        end
        ckg_pkg::ST_ACK_R: begin
          if (scl_rise) begin
            if (ser_s[0]) begin
              state_q <= ckg_pkg::ST_IDLE;
            end else begin
              ack_on_q <= 1'b1;
            end
          end else if (scl_fall && ack_on_q) begin
            ack_on_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            shreg_q <= tx_byte;
            o_sda_oe <= ~tx_byte[7];
            byte_idx_q <= idx_next;
            state_q <= ckg_pkg::ST_TX;
          end
        end
        ckg_pkg::ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        default: begin
          state_q <= ckg_pkg::ST_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain value: only ever pulls low
  always_ff @(posedge i_clk) begin
    o_sda <= 1'b0;
  end

  // ==========================================================================
  // Frequency and spread outputs
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_freq_sel <= 4'h0;
      o_spread_on <= 1'b0;
      o_spread_down <= 1'b0;
    end else begin
      o_freq_sel <= cfg_q[0][ckg_pkg::B0_FREQ_SRC] ? {cfg_q[0][2], cfg_q[0][6:4]}
        : strap_q[ckg_pkg::STRAP_FS3:ckg_pkg::STRAP_FS0];
      o_spread_on <= cfg_q[0][ckg_pkg::B0_SPREAD_ON];
      o_spread_down <= cfg_q[0][ckg_pkg::B0_SPREAD_DOWN];
    end
  end

  // ==========================================================================
  // Crossing into the processor clock domain
  logic [31:0] en_flat;
  logic [36:0] proc_s;
  logic proc_rstn;
  logic mode_s;
  logic [31:0] en_s;
  logic proc_halt_n_s;
  logic bus_halt_n_s;
  logic buf_s;

  assign en_flat = {cfg_q[5], cfg_q[3], cfg_q[2], cfg_q[1]};

  // Enables are quasi-static, halts pass two stages before acting
  ckg_sync #(.WIDTH(37)) u_proc_sync (
    .i_clk(i_proc_clk),
    .i_d({i_rstn, strap_q[ckg_pkg::STRAP_MODE], en_flat, i_proc_halt_n, i_reference_out_zero_pin,
      i_mem_buf_in}),
    .o_q(proc_s)
  );

  assign {proc_rstn, mode_s, en_s, proc_halt_n_s, bus_halt_n_s, buf_s} = proc_s;

  // ==========================================================================
  // Dividers for bus and fixed-rate outputs
  logic [1:0] bus_div_q;
  logic [1:0] aux_div_q;
  logic bus_tick;
  logic aux_tick;
  logic bus_go;

  always_ff @(posedge i_proc_clk) begin
    if (!proc_rstn) begin
      bus_div_q <= 2'h0;
      aux_div_q <= 2'h0;
    end else begin
      bus_div_q <= bus_tick ? 2'h0 : bus_div_q + 2'h1;
      aux_div_q <= aux_tick ? 2'h0 : aux_div_q + 2'h1;
    end
  end

  assign bus_tick = (bus_div_q == ckg_pkg::BUS_DIV_LAST);
  assign aux_tick = (aux_div_q == ckg_pkg::AUX_DIV_LAST);
  // Desktop mode: shared pin is an output and never halts the bus
  assign bus_go = mode_s | bus_halt_n_s;

  // ==========================================================================
  // Gated clock groups
  logic [3:0] proc_q;
  logic [5:0] bus_q;
  logic [3:0] aux_q;

  ckg_gate #(.WIDTH(4)) u_proc_gate (
    .i_clk(i_proc_clk),
    .i_rstn(proc_rstn),
    .i_tick(1'b1),
    .i_run({en_s[ckg_pkg::EN_PROC_FREE], en_s[ckg_pkg::EN_PROC0 +: 3] & {3{proc_halt_n_s}}}),
    .o_q(proc_q)
  );

  ckg_gate #(.WIDTH(6)) u_bus_gate (
    .i_clk(i_proc_clk),
    .i_rstn(proc_rstn),
    .i_tick(bus_tick),
    .i_run({en_s[ckg_pkg::EN_BUS_FREE], en_s[ckg_pkg::EN_BUS0 +: 5] & {5{bus_go}}}),
    .o_q(bus_q)
  );

  ckg_gate #(.WIDTH(4)) u_aux_gate (
    .i_clk(i_proc_clk),
    .i_rstn(proc_rstn),
    .i_tick(aux_tick),
    .i_run({en_s[ckg_pkg::EN_REF1], en_s[ckg_pkg::EN_REFERENCE_OUT_ZERO], en_s[ckg_pkg::EN_24M],
      en_s[ckg_pkg::EN_48M]}),
    .o_q(aux_q)
  );

  assign o_processor_clock_out = proc_q[2:0];
  assign o_bus_clock_out = bus_q[4:1];
  assign o_strap_pin = {bus_q[5], bus_q[0], proc_q[3], aux_q[1], aux_q[0]};
  assign o_reference_out_zero = aux_q[2];
  assign o_ref1 = aux_q[3];

  // ==========================================================================
  // Memory fanout from buffer input
  logic buf_q;
  logic [11:0] mem_en;

  assign mem_en = {en_s[ckg_pkg::EN_MEM_HI +: 8], en_s[ckg_pkg::EN_MEM_LO +: 4]};

  // Gated outputs rise only on a buffer rising edge, so no runt high
  always_ff @(posedge i_proc_clk) begin
    if (!proc_rstn) begin
      buf_q <= 1'b0;
      o_mem_clock_out <= 12'h000;
      o_mem_free <= 1'b0;
    end else begin
      buf_q <= buf_s;
      o_mem_clock_out <= {12{buf_s}} & mem_en
        & (o_mem_clock_out | {12{proc_halt_n_s & ~buf_q}});
      o_mem_free <= buf_s & en_s[ckg_pkg::EN_MEM_FREE];
    end
  end

  // ==========================================================================
  // Assertions
  addr_ack_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state_q == ckg_pkg::ST_ADDR) && scl_rise && (bit_cnt_q == ckg_pkg::BIT_LAST)
    && (shreg_q[6:0] == ckg_pkg::SLAVE_ADDR7) |-> ##[1:ACK_WAIT] o_sda_oe)
    else $error("address not acknowledged");
  byte_store_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    wr_en |=> cfg_q[$past(wr_idx)] == $past(wr_data))
    else $error("config byte not stored");
  strap_inv_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    strap_done_q |-> rd_byte(4'h2) == {~strap_q[ckg_pkg::STRAP_FS2], cfg_q[1][6:0]})
    else $error("strap read-back not inverted");
  pin_input_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !strap_done_q |-> ##1 (o_strap_oe == ckg_pkg::STRAP_NONE))
    else $error("strap pins driven during latch");
  proc_stop_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    $fell(proc_halt_n_s) |-> ##1 (o_processor_clock_out == 3'h0) [*3])
    else $error("processor clocks not stopped in time");
  proc_start_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    $rose(proc_halt_n_s) && en_s[ckg_pkg::EN_PROC0] |-> ##1 o_processor_clock_out[0])
    else $error("processor clock restart late");
  proc_low_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    !proc_halt_n_s && !proc_q[0] |=> !proc_q[0])
    else $error("halted processor clock rose");
  free_run_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    !proc_halt_n_s && $past(en_s[ckg_pkg::EN_PROC_FREE]) |-> $changed(proc_q[3]))
    else $error("free processor clock disturbed");
  mem_low_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    !proc_halt_n_s && !o_mem_clock_out[0] |=> !o_mem_clock_out[0])
    else $error("halted memory clock rose");
  bus_halt_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    !mode_s && !bus_halt_n_s && bus_tick |=> !bus_q[1])
    else $error("bus clock not halted low");
  desk_bus_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    mode_s && bus_tick && en_s[ckg_pkg::EN_BUS0] && !bus_q[0] |=> bus_q[0])
    else $error("bus clock halted in desktop mode");
  free_bus_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    bus_tick && en_s[ckg_pkg::EN_BUS_FREE] && !bus_q[5] |=> bus_q[5])
    else $error("free bus clock stopped");
  off_low_a: assert property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    !en_s[ckg_pkg::EN_PROC0] |=> !proc_q[0])
    else $error("disabled clock toggled");

  last_byte_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    wr_en && (wr_idx == 3'h5));
  read_back_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
    (state_q == ckg_pkg::ST_ACK_R) && scl_fall && ack_on_q);
  proc_halt_c: cover property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    $rose(proc_halt_n_s));
  bus_halt_c: cover property (@(posedge i_proc_clk) disable iff (!proc_rstn)
    !mode_s && $rose(bus_halt_n_s));

endmodule : ckg_ctrl

/* File: ckg_host.sv */
// Host model of the two-wire serial bus: start, stop and byte transfers.
// Assumes the bench resolves the data line from both drive enables with a pull-up.
`timescale 1ns/1ps

module ckg_host #(
  parameter int QTR = 250 // Quarter bit in system clocks, 100 kHz bit rate
) (
  input wire logic i_clk, // System clock
  input wire logic i_sda, // Resolved data line
  output logic o_scl, // Serial clock drive
  output logic o_sda_oe // High pulls data low
);
  // ==========================================================================
  // Bus sequencing
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end
  // One quarter of a bit time
  task automatic quarter();
    repeat (QTR) @(posedge i_clk);
  endtask : quarter
  // Start or repeated start, clock left low
  task automatic start();
    o_sda_oe <= 1'b0;
    quarter();
    o_scl <= 1'b1;
    quarter();
    o_sda_oe <= 1'b1;
    quarter();
    o_scl <= 1'b0;
    quarter();
  endtask : start
  // Data set in clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe <= ~b;
    quarter();
    o_scl <= 1'b1;
    quarter();
    r = i_sda;
    quarter();
    o_scl <= 1'b0;
    quarter();
  endtask : bit_io
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask : xfer
  // Stop condition, bus left idle high
  task automatic stop();
    o_sda_oe <= 1'b1;
    quarter();
    o_scl <= 1'b1;
    quarter();
    o_sda_oe <= 1'b0;
    quarter();
  endtask : stop
endmodule : ckg_host

/* File: clock_gen_ctrl_and_stop_logic_tb_top.sv */
// Bench for the clock generator control: straps, clock halts, serial write and read.
// Assumes pins resolve here: straps 0a, pull-up on data, shared pin at bhalt_n when not driven.
`timescale 1ns/1ps

module clock_gen_ctrl_and_stop_logic_tb_top;
  logic i_clk = 1'b0, i_rstn = 1'b0, pc = 1'b0, halt_n = 1'b1, bhalt_n = 1'b1;
  logic scl, h_oe, sda_oe, osda, reference_out_zero, reference_out_zero_oe, ref1, mfree, spon, spdn, ak;
  logic [4:0] spin, soe, b_tog, b_prev, spull = 5'h0a;
  logic [4:1] bclk;
  logic [2:0] pclk;
  logic [6:0] f_tog, f_prev;
  logic [3:0] fsel, div_q = 4'h0;
  logic [11:0] mclk;
  logic [14:0] g_tog, g_prev;
  logic [7:0] rx;
  logic [7:0] wr [5] = '{8'hd2, 8'h55, 8'h00, 8'h9e, 8'h78};
  logic [7:0] rd [4] = '{8'h06, 8'h9e, 8'hf8, 8'hff};
  int fail_count = 0, n_tests = 0, clr_req = 0, clr_ack = 0;
  wire logic sda = ~(h_oe | (sda_oe & ~osda));
  wire logic [4:0] strap_w = (soe & spin) | (~soe & spull);
  wire logic [6:0] f_now = {spin[2], mfree, spin[4], ref1, reference_out_zero, spin[1:0]};
  wire logic reference_out_zero_w = reference_out_zero_oe ? reference_out_zero : bhalt_n;
  // ==========================================================================
  // Clocks, buffer input and toggle watch
  always #5 i_clk = ~i_clk;
  always #16 pc = ~pc;
  always @(posedge i_clk) div_q <= div_q + 4'h1;
  // Clear requests act at the next processor edge
  always @(posedge pc) begin
    g_prev <= {pclk, mclk};
    b_prev <= {bclk, spin[3]};
    f_prev <= f_now;
    if (clr_ack != clr_req) begin
      clr_ack <= clr_req;
      g_tog <= '0;
      b_tog <= '0;
      f_tog <= '0;
    end else begin
      g_tog <= g_tog | (g_prev ^ {pclk, mclk});
      b_tog <= b_tog | (b_prev ^ {bclk, spin[3]});
      f_tog <= f_tog | (f_prev ^ f_now);
    end
  end
  ckg_host i_ckg_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(h_oe));
  ckg_ctrl i_ckg_ctrl (.i_clk(i_clk), .i_rstn(i_rstn), .i_proc_clk(pc), .i_scl(scl),
    .i_sda(sda), .o_sda(osda), .o_sda_oe(sda_oe), .i_strap_pin(strap_w), .o_strap_pin(spin),
    .o_strap_oe(soe), .i_reference_out_zero_pin(reference_out_zero_w), .o_reference_out_zero(reference_out_zero), .o_reference_out_zero_oe(reference_out_zero_oe),
    .o_ref1(ref1), .i_proc_halt_n(halt_n), .i_mem_buf_in(div_q[3]),
    .o_processor_clock_out(pclk), .o_bus_clock_out(bclk), .o_mem_clock_out(mclk),
    .o_mem_free(mfree), .o_freq_sel(fsel), .o_spread_on(spon), .o_spread_down(spdn));
  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic pe(input int n);
    repeat (n) @(posedge pc);
    @(posedge i_clk);
  endtask : pe
  task automatic clr();
    clr_req++;
  endtask : clr
  task automatic end_sim();
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("strap oe", soe, 5'h1f);
    chk("reference_out_zero oe", reference_out_zero_oe, 1'b0);
    chk("freq sel", fsel, 4'ha);
    chk("spread", {spon, spdn}, 2'b00);
    pe(4);
    halt_n <= 1'b0;
    pe(8);
    clr();
    pe(16);
    chk("proc halt gated", {g_tog, pclk}, 18'h0);
    chk("proc halt others", {f_tog, b_tog}, 12'hfff);
    halt_n <= 1'b1;
    clr();
    pe(4);
    chk("proc restart", g_tog[14:12], 3'h7);
    clr();
    pe(100);
    chk("mem running", g_tog[11:0], 12'hfff);
    bhalt_n <= 1'b0;
    pe(6);
    clr();
    pe(16);
    chk("bus halt gated", b_tog, 5'h0);
    chk("bus halt others", {f_tog, g_tog[14:12]}, 10'h3ff);
    bhalt_n <= 1'b1;
    clr();
    pe(6);
    chk("bus restart", b_tog, 5'h1f);
    pe(20);
    i_ckg_host.start();
    i_ckg_host.xfer(8'ha4, 1'b1, rx, ak);
    chk("foreign addr", ak, 1'b1);
    i_ckg_host.stop();
    i_ckg_host.start();
    for (int i = 0; i < 5; i++) begin
      i_ckg_host.xfer(wr[i], 1'b1, rx, ak);
      chk("write ack", ak, 1'b0);
    end
    i_ckg_host.stop();
    pe(4);
    chk("write fields", {fsel, spon, spdn}, 6'h27);
    clr();
    pe(16);
    chk("proc disabled", {g_tog[14:12], pclk}, 6'h0);
    i_ckg_host.start();
    i_ckg_host.xfer(8'hd3, 1'b1, rx, ak);
    chk("read ack", ak, 1'b0);
    for (int i = 0; i < 4; i++) begin
      i_ckg_host.xfer(8'hff, i == 3, rx, ak);
      chk("read byte", rx, rd[i]);
    end
    i_ckg_host.stop();
    spull <= 5'h15;
    bhalt_n <= 1'b0;
    i_rstn <= 1'b0;
    repeat (14) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("desk oe", {soe, reference_out_zero_oe}, 6'h3f);
    chk("desk defaults", {fsel, spon, spdn}, 6'h14);
    pe(8);
    clr();
    pe(16);
    chk("desk clocks", {b_tog, g_tog[14:12]}, 8'hff);
    end_sim();
  end
endmodule : clock_gen_ctrl_and_stop_logic_tb_top
